// File: dv/mers_host_model.sv
// Purpose: Host driving enable, reset and feedback pins
// Assumes: Pins change on the falling edge
// Notes: Feedback stands still unless spun
module mers_host_model (
  input wire logic clk_in,
  output logic enable_pin_out = 1'b0, reset_pin_out = 1'b0, spd_fb_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Caller keeps inactive spells past the low time
  task automatic drive(input logic en, input logic rst, input int hold);
    @(negedge clk_in);
    enable_pin_out = en;
    reset_pin_out = rst;
    repeat (hold) @(negedge clk_in);
  endtask : drive
  task automatic spin(input int k);
    repeat (k) @(negedge clk_in) spd_fb_out = ~spd_fb_out;
  endtask : spin
endmodule : mers_host_model

// File: dv/mers_monitor.sv
// Purpose: Port assertions for the sequencer
// Assumes: One clock, shortened stop and low counts
// Notes: Bound from the bench top
module mers_monitor (
  input wire logic clk_in, rst_n_in, enable_pin_in, reset_pin_in, enable_polarity_select_in,
  input wire logic brake_or_coast_select_in, motor_enable_out, brake_out,
  input wire logic aux_five_volt_regulator_en_out, int_clock_en_out, otp_reload_out, asleep_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_stop; (enable_pin_in == enable_polarity_select_in) [*8] |-> ##[0:4] !motor_enable_out; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_brk; brake_out |-> !motor_enable_out && brake_or_coast_select_in; endproperty
  a_brk: assert property (p_brk) else $error("bad brake");
  property p_rdy; $rose(asleep_out) |-> !$past(motor_enable_out, 8); endproperty
  a_rdy: assert property (p_rdy) else $error("early sleep");
  property p_slp; asleep_out |-> !int_clock_en_out && !motor_enable_out; endproperty
  a_slp: assert property (p_slp) else $error("awake in sleep");
  property p_run; $fell(motor_enable_out) |-> !motor_enable_out [*8]; endproperty
  a_run: assert property (p_run) else $error("stop cut");
  property p_rl; otp_reload_out |-> !motor_enable_out ##1 !otp_reload_out; endproperty
  a_rl: assert property (p_rl) else $error("bad reload");
  property p_hold; otp_reload_out ##1 reset_pin_in [*4] |-> !motor_enable_out; endproperty
  a_hold: assert property (p_hold) else $error("hold lost");
  property p_reg; !asleep_out && $past(rst_n_in) |-> aux_five_volt_regulator_en_out; endproperty
  a_reg: assert property (p_reg) else $error("regulator off");
endmodule : mers_monitor

// File: dv/mers_sequencer_tb.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Stop and low counts shortened
// Notes: Every wait is bounded and ends the run
module mers_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STP = 50;
  logic clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, enable_polarity_select_in = 1'b0;
  logic brake_or_coast_select_in = 1'b0, regulator_always_on_in = 1'b0, enable_pin_in, reset_pin_in;
  logic speed_feedback_output_in, motor_enable_out, brake_out, aux_five_volt_regulator_en_out, power_switch_en_out;
  logic core_power_en_out, int_clock_en_out, serial_port_en_out, speed_param_wr_en_out, otp_reload_out;
  logic fault_clear_out, loop_init_out, asleep_out;
  wire logic [2:0] ob = {asleep_out, otp_reload_out, motor_enable_out};
  int miscompares = 0, total_checks = 0, n;
  initial forever #25 clk_in = ~clk_in;
  int cycles = 0;
  // Ceiling well above the sum of all scenario waits
  always @(negedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  mers_host_model i_host (.clk_in(clk_in), .enable_pin_out(enable_pin_in), .reset_pin_out(reset_pin_in),
    .spd_fb_out(speed_feedback_output_in));
  mers_sequencer #(.STOP_CYCLES(STP), .EN_LOW_CYCLES(4)) i_dut (.*);
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic c, input string m);
    total_checks++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  // Bounded wait; running out means a hang
  task automatic till(input int i);
    for (n = 0; ob[i] !== 1'b1; n++) begin
      if (n == 300) begin
        miscompares++;
        summarize();
      end
      @(negedge clk_in);
    end
  endtask : till
  task automatic t_stop(input logic b);
    brake_or_coast_select_in = b;
    regulator_always_on_in = b;
    i_host.drive(0, 0, 10);
    chk(ob[0] === 1'b0 && brake_out === b, "stop");
    i_host.drive(1, 0, 0);
    i_host.spin(6);
    till(2);
    chk(n >= STP && n < STP + 9 && aux_five_volt_regulator_en_out === b, "sleep");
    chk(int_clock_en_out === 1'b0 && serial_port_en_out === 1'b1, "off");
    till(0);
    chk(n < 12, "rerun");
  endtask : t_stop
  task automatic t_reset();
    i_host.drive(1, 1, 0);
    i_host.spin(4);
    till(1);
    chk(n >= STP && fault_clear_out === 1'b1 && loop_init_out === 1'b1, "reload");
    i_host.drive(1, 1, 20);
    chk(ob[0] === 1'b0, "hold");
    i_host.drive(1, 0, 0);
    till(0);
    chk(n < 12, "go");
  endtask : t_reset
  task automatic t_tie();
    enable_polarity_select_in = 1'b1;
    i_host.drive(0, 0, 0);
    till(2);
    chk(n > STP - 5, "pol");
    till(0);
    i_host.drive(1, 1, 0);
    till(2);
    i_host.drive(0, 0, 0);
    till(1);
    chk(n < 12, "tied");
    till(0);
    chk(n < 12, "run");
  endtask : t_tie
  // A reset pulse seen only while frozen must leave the motor running
  task automatic t_ce();
    ce_in = 1'b0;
    i_host.drive(0, 1, 12);
    chk(ob[0] === 1'b1, "frozen");
    i_host.drive(0, 0, 0);
    ce_in = 1'b1;
    i_host.drive(0, 0, 8);
    chk(ob[0] === 1'b1 && ob[2] === 1'b0, "thawed");
  endtask : t_ce
  initial begin
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    i_host.drive(1, 0, 0);
    till(0);
    chk(n < 12 && aux_five_volt_regulator_en_out === 1'b1, "wake");
    t_stop(1'b0);
    t_stop(1'b1);
    t_reset();
    t_tie();
    t_ce();
    summarize();
  end
endmodule : mers_sequencer_tb
bind mers_sequencer mers_monitor i_mon (.*);

// File: hdl/mers_sequencer.sv
// Purpose: Enable/reset sequencing of a three-phase motor controller core.
// Assumes: Pins are asynchronous; configuration bits come from core logic on clk_in.
// Notes: Serial port and speed-loop registers live outside; this block only gates them.
module mers_sequencer
  import mers_pkg::*;
#(
  parameter int unsigned STOP_CYCLES = STOP_CYC,
  parameter int unsigned EN_LOW_CYCLES = EN_LOW_CYC
) (
  // Clock, reset, clock enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Pins from host
  input wire logic enable_pin_in,
  input wire logic reset_pin_in,
  input wire logic speed_feedback_output_in,
  // Configuration
  input wire logic enable_polarity_select_in,
  input wire logic brake_or_coast_select_in,
  input wire logic regulator_always_on_in,
  // Motor and power control
  output logic motor_enable_out,
  output logic brake_out,
  output logic aux_five_volt_regulator_en_out,
  output logic power_switch_en_out,
  output logic core_power_en_out,
  output logic int_clock_en_out,
  output logic serial_port_en_out,
  output logic speed_param_wr_en_out,
  output logic otp_reload_out,
  output logic fault_clear_out,
  output logic loop_init_out,
  output logic asleep_out
);
  localparam int CW = $clog2(STOP_CYCLES + 1);
  localparam int DW = $clog2(EN_LOW_CYCLES + 1);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [CW-1:0] cnt_inc(input logic [CW-1:0] v);
    cnt_inc = v + 1'b1;
  endfunction : cnt_inc

  // True once the enable has been inactive for the full filter time
  function automatic logic low_done(input logic [DW-1:0] v);
    low_done = (v >= DW'(EN_LOW_CYCLES));
  endfunction : low_done

  // Every state but sleep keeps the core powered and clocked
  function automatic logic is_awake(input mers_state_t s);
    is_awake = (s != MERS_SLEEP);
  endfunction : is_awake

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] en_s_r, en_s_nxt, rs_s_r, rs_s_nxt, fg_s_r, fg_s_nxt;
  logic fg_d_r, fg_d_nxt;
  always_comb begin
    en_s_nxt = {en_s_r[0], enable_pin_in};
    rs_s_nxt = {rs_s_r[0], reset_pin_in};
    fg_s_nxt = {fg_s_r[0], speed_feedback_output_in};
    fg_d_nxt = fg_s_r[1];
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      en_s_r <= 2'h0;
      rs_s_r <= 2'h0;
      fg_s_r <= 2'h0;
      fg_d_r <= 1'b0;
    end else if (ce_in) begin
      en_s_r <= en_s_nxt;
      rs_s_r <= rs_s_nxt;
      fg_s_r <= fg_s_nxt;
      fg_d_r <= fg_d_nxt;
    end
  end

  // Reset pin is active high; enable active level set by polarity select (1 = active low)
  logic en_act, rs_act, fg_edge;
  assign en_act = en_s_r[1] ^ enable_polarity_select_in;
  assign rs_act = rs_s_r[1];
  assign fg_edge = fg_s_r[1] ^ fg_d_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  mers_state_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic rst_pend_r, rst_pend_nxt, rst_seq_r, rst_seq_nxt;
  logic off_req, tmo;

  // ----------------------------------------
  // Enable-low filter and polarity watch
  // ----------------------------------------
  // Counter saturates so a long sleep cannot wrap it back below the limit
  logic [DW-1:0] dis_r, dis_nxt;
  logic pol_r, pol_nxt;
  always_comb begin
    pol_nxt = enable_polarity_select_in;
    dis_nxt = en_act ? '0 : (low_done(dis_r) ? dis_r : dis_r + 1'b1);
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dis_r <= '0;
      pol_r <= 1'b0;
    end else if (ce_in) begin
      dis_r <= dis_nxt;
      pol_r <= pol_nxt;
    end
  end

  // Filter keeps short enable glitches from stopping the motor
  assign off_req = low_done(dis_r) || (pol_r != enable_polarity_select_in);
  // Compare is one short so the stop lasts exactly STOP_CYCLES cycles
  assign tmo = (cnt_r >= CW'(STOP_CYCLES - 1));

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rst_pend_nxt = rst_pend_r;
    rst_seq_nxt = rst_seq_r;
    case (st_r)
      MERS_SLEEP: begin
        if (rs_act) begin
          rst_pend_nxt = 1'b1;
        end
        if (en_act) begin
          st_nxt = rst_pend_r || rs_act ? MERS_RELOAD : MERS_RUN;
          rst_pend_nxt = 1'b0;
        end
      end
      MERS_RUN: begin
        cnt_nxt = '0;
        if (off_req) begin
          st_nxt = MERS_STOP;
          rst_seq_nxt = 1'b0;
        end else if (rs_act && en_act) begin
          // Reset while still enabled starts the stop and goes on to reload once the stop times out
          st_nxt = MERS_STOP;
          rst_seq_nxt = 1'b1;
        end
      end
      MERS_STOP: begin
        // Enable is ignored here so a started stop always finishes
        if (!rst_seq_r && rs_act) begin
          rst_pend_nxt = 1'b1;
        end
        if (fg_edge) begin
          cnt_nxt = '0;
        end else if (tmo) begin
          cnt_nxt = '0;
          st_nxt = rst_seq_r ? MERS_RELOAD : MERS_SLEEP;
        end else begin
          cnt_nxt = cnt_inc(cnt_r);
        end
      end
      MERS_RELOAD: begin
        st_nxt = MERS_HOLD;
        rst_seq_nxt = 1'b0;
      end
      MERS_HOLD: begin
        if (!rs_act) begin
          st_nxt = MERS_RUN;
        end
      end
      default: begin
        st_nxt = MERS_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= MERS_SLEEP;
      cnt_r <= '0;
      rst_pend_r <= 1'b0;
      rst_seq_r <= 1'b0;
    end else if (ce_in) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rst_pend_r <= rst_pend_nxt;
      rst_seq_r <= rst_seq_nxt;
    end
  end

  // ----------------------------------------
  // Motor drive outputs
  // ----------------------------------------
  // Taken from the next state so outputs move on the same edge as the state
  // Brake only while stopping; coast leaves all gates off
  logic mot_nxt, brk_nxt;
  logic mot_r, brk_r;
  always_comb begin
    mot_nxt = (st_nxt == MERS_RUN) && !off_req;
    brk_nxt = (st_nxt == MERS_STOP) && brake_or_coast_select_in;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mot_r <= RST_MOTOR_ON;
      brk_r <= 1'b0;
    end else if (ce_in) begin
      mot_r <= mot_nxt;
      brk_r <= brk_nxt;
    end
  end

  // ----------------------------------------
  // Power, clock and regulator outputs
  // ----------------------------------------
  // Power switch and core share one decode but keep their own flops
  logic pwr_nxt, core_nxt, clk_nxt, reg_nxt, slp_nxt;
  logic pwr_r, core_r, clk_r, reg_r, slp_r;
  always_comb begin
    pwr_nxt = is_awake(st_nxt);
    core_nxt = is_awake(st_nxt);
    clk_nxt = is_awake(st_nxt);
    // With the always-on bit set the regulator also feeds the sensors in sleep
    reg_nxt = regulator_always_on_in || is_awake(st_nxt);
    slp_nxt = !is_awake(st_nxt);
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pwr_r <= 1'b0;
      core_r <= 1'b0;
      clk_r <= 1'b0;
      reg_r <= 1'b0;
      slp_r <= 1'b1;
    end else if (ce_in) begin
      pwr_r <= pwr_nxt;
      core_r <= core_nxt;
      clk_r <= clk_nxt;
      reg_r <= reg_nxt;
      slp_r <= slp_nxt;
    end
  end

  // ----------------------------------------
  // Reload pulses
  // ----------------------------------------
  // One-cycle pulse; the core reloads, clears faults and resets the loop on it
  logic rld_nxt, flt_nxt, ini_nxt;
  logic rld_r, flt_r, ini_r;
  always_comb begin
    rld_nxt = (st_nxt == MERS_RELOAD);
    flt_nxt = (st_nxt == MERS_RELOAD);
    ini_nxt = (st_nxt == MERS_RELOAD);
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rld_r <= 1'b0;
      flt_r <= 1'b0;
      ini_r <= 1'b0;
    end else if (ce_in) begin
      rld_r <= rld_nxt;
      flt_r <= flt_nxt;
      ini_r <= ini_nxt;
    end
  end

  // ----------------------------------------
  // Serial and speed-loop access gates
  // ----------------------------------------
  // Serial access and speed-loop writes stay open in every state, sleep included
  // Held in flops so every port leaves a register
  logic ser_nxt, spw_nxt;
  logic ser_r, spw_r;
  always_comb begin
    ser_nxt = 1'b1;
    spw_nxt = 1'b1;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ser_r <= 1'b1;
      spw_r <= 1'b1;
    end else if (ce_in) begin
      ser_r <= ser_nxt;
      spw_r <= spw_nxt;
    end
  end

  // ----------------------------------------
  // Output ports
  // ----------------------------------------
  assign motor_enable_out = mot_r;
  assign brake_out = brk_r;
  assign aux_five_volt_regulator_en_out = reg_r;
  assign power_switch_en_out = pwr_r;
  assign core_power_en_out = core_r;
  assign int_clock_en_out = clk_r;
  assign serial_port_en_out = ser_r;
  assign speed_param_wr_en_out = spw_r;
  assign otp_reload_out = rld_r;
  assign fault_clear_out = flt_r;
  assign loop_init_out = ini_r;
  assign asleep_out = slp_r;
endmodule : mers_sequencer

// File: shared/mers_pkg.sv
// Purpose: Constants and types for the motor enable/reset sequencer.
// Assumes: 20 MHz system clock.
// Notes: Timing counts derive from times in their own units.
// Contract
// - Enable deassert while running starts stop sequence
// - First step brakes or coasts per select
// - Stopped means no feedback edges for 1 s
// - Then power down, regulator off, clocks stopped
// - Serial register access stays alive in sleep
// - Enable low 1.2 us, or polarity change
// - Started sequence always runs to completion
// - Reset during power-down acted on at wake
// - Reset while enabled: stop, 1 s, reload
// - Motor held off while reset stays asserted
// - Enable tied to reset, active low works
// - Speed-loop updates accepted at any time
// - Regulator on with enable unless always-on set
package mers_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned EN_LOW_NS = 1200;
  localparam int unsigned EN_LOW_CYC = (EN_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned STOP_MS = 1000;
  localparam int unsigned STOP_CYC = STOP_MS * (CLK_HZ / 1000);
  localparam logic RST_MOTOR_ON = 1'b0;

  typedef enum logic [2:0] {
    MERS_SLEEP = 3'b000,
    MERS_RUN = 3'b001,
    MERS_STOP = 3'b011,
    MERS_RELOAD = 3'b010,
    MERS_HOLD = 3'b110
  } mers_state_t;
endpackage : mers_pkg
